// ==== core/fls_host.sv ====
// Host controller: APB registers to flash command writes, status polling and pin monitoring
`timescale 1ns/100ps
module fls_host #(
	parameter logic [7:0] OPC_CLR_SETUP   = 8'h60,
	parameter logic [7:0] OPC_CLR_CONFIRM = 8'hd0,
	parameter logic [7:0] OPC_READ_SR     = 8'h70,
	parameter logic [7:0] OPC_CLEAR_SR    = 8'h50,
	parameter logic [7:0] OPC_READ_XSR    = 8'h71
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output fls_pkg::fls_pins_t     flash,
	input  wire logic [7:0]        flash_dq_in,
	input  wire logic              completion_output_pin
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_CL_SETUP, ST_CL_CONF, ST_POLL_CMD, ST_POLL_RD, ST_CHECK, ST_CLR_SR,
		ST_CF_STCMD, ST_CF_STRD, ST_CF_CHK, ST_CF_CMD, ST_CF_DATA, ST_XSR_CMD, ST_XSR_RD
	} fls_state_t;

	localparam logic [7:0] WR_LAST = 8'(fls_pkg::WE_CYC + fls_pkg::GAP_CYC - 1);
	localparam logic [7:0] RD_LAST = 8'(fls_pkg::RD_CYC + fls_pkg::GAP_CYC - 1);
	localparam logic [7:0] RD_SMP  = 8'(fls_pkg::RD_CYC - 1);

	fls_state_t         state_reg, state_next;
	logic [7:0]         cnt_reg, cnt_next;
	logic [9:0]         ctrl_reg, ctrl_next;
	logic [7:0]         sr_reg, sr_next, xsr_reg, xsr_next;
	logic [1:0]         mode_reg, mode_next;
	logic               is_clear_reg, is_clear_next;
	logic               done_reg, done_next, refused_reg, refused_next;
	logic               undef_reg, undef_next, pulse_reg, pulse_next;
	logic [31:0]        prdata_reg, prdata_next;
	logic               pready_reg, pready_next, pslverr_reg, pslverr_next;
	fls_pkg::fls_pins_t pins_reg, pins_next;
	logic [7:0]         dq_s1_reg, dq_s2_reg;
	logic               pin_level, pin_done;
	logic               wr_take, cmd_take, bus_done, is_write_st, is_read_st;

	fls_sts_mon u_mon (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     (completion_output_pin),
		.level      (pin_level),
		.done_pulse (pin_done)
	);

	function automatic logic [7:0] cmd_byte(input fls_state_t st, input logic [1:0] code);
		unique case (st)
			ST_CL_SETUP: cmd_byte = OPC_CLR_SETUP;
			ST_CL_CONF:  cmd_byte = OPC_CLR_CONFIRM;
			ST_CLR_SR:   cmd_byte = OPC_CLEAR_SR;
			ST_CF_CMD:   cmd_byte = fls_pkg::OPC_PIN_CONFIG;
			ST_CF_DATA:  cmd_byte = {6'h00, code} & fls_pkg::CFG_CODE_MASK;
			ST_XSR_CMD:  cmd_byte = OPC_READ_XSR;
			default:     cmd_byte = OPC_READ_SR;
		endcase
	endfunction

	always_comb begin
		is_write_st = state_reg inside {ST_CL_SETUP, ST_CL_CONF, ST_POLL_CMD, ST_CLR_SR,
			ST_CF_STCMD, ST_CF_CMD, ST_CF_DATA, ST_XSR_CMD};
		is_read_st  = state_reg inside {ST_POLL_RD, ST_CF_STRD, ST_XSR_RD};
		bus_done    = (is_write_st && cnt_reg == WR_LAST) || (is_read_st && cnt_reg == RD_LAST);
		wr_take     = psel && penable && pready_reg && pwrite;
		cmd_take    = wr_take && paddr == fls_pkg::REG_CMD;
	end

	// APB slave: registered answer, one access cycle, zero wait states
	always_comb begin
		pready_next  = psel && !penable;
		prdata_next  = 32'h0000_0000;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			unique case (paddr)
				fls_pkg::REG_CTRL: prdata_next = {22'h000000, ctrl_reg};
				fls_pkg::REG_CMD:  prdata_next = 32'h0000_0000;
				fls_pkg::REG_STAT: begin
					prdata_next[7:0] = sr_reg;
					prdata_next[fls_pkg::STAT_XSR_LSB +: 8] = xsr_reg;
					prdata_next[fls_pkg::STAT_BUSY]     = state_reg != ST_IDLE;
					prdata_next[fls_pkg::STAT_DONE]     = done_reg;
					prdata_next[fls_pkg::STAT_REFUSED]  = refused_reg;
					prdata_next[fls_pkg::STAT_LOCK_UND] = undef_reg;
					prdata_next[fls_pkg::STAT_PIN_LVL]  = pin_level;
					prdata_next[fls_pkg::STAT_PULSE]    = pulse_reg;
					prdata_next[fls_pkg::STAT_MODE_LSB +: 2] = mode_reg;
				end
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	// Sequencer
	always_comb begin
		state_next    = state_reg;
		cnt_next      = bus_done ? 8'h00 : cnt_reg + 8'h01;
		ctrl_next     = ctrl_reg;
		sr_next       = sr_reg;
		xsr_next      = xsr_reg;
		mode_next     = mode_reg;
		is_clear_next = is_clear_reg;
		done_next     = done_reg;
		refused_next  = refused_reg;
		undef_next    = undef_reg;
		pulse_next    = pulse_reg;
		if (state_reg == ST_IDLE)
			cnt_next = 8'h00;
		if (wr_take && paddr == fls_pkg::REG_CTRL)
			ctrl_next = pwdata[9:0];
		if (cmd_take) begin
			if (state_reg != ST_IDLE || ctrl_reg[fls_pkg::CTRL_PD_BIT]) begin
				refused_next = 1'b1;
			end else begin
				refused_next  = 1'b0;
				done_next     = 1'b0;
				pulse_next    = 1'b0;
				is_clear_next = 1'b0;
				unique case (pwdata[2:0])
					fls_pkg::OP_CLEAR_LOCKS: begin
						// Without protect high the device would reject the clear
						if (ctrl_reg[fls_pkg::CTRL_WP_BIT]) begin
							state_next    = ST_CL_SETUP;
							is_clear_next = 1'b1;
						end else begin
							refused_next = 1'b1;
						end
					end
					fls_pkg::OP_CONFIG_PIN: state_next = ST_CF_STCMD;
					fls_pkg::OP_CLEAR_SR:   state_next = ST_CLR_SR;
					fls_pkg::OP_READ_SR:    state_next = ST_POLL_CMD;
					fls_pkg::OP_READ_XSR:   state_next = ST_XSR_CMD;
					default:                refused_next = 1'b1;
				endcase
			end
		end
		if (pin_done && mode_reg != 2'h0)
			pulse_next = 1'b1;
		if (bus_done) begin
			unique case (state_reg)
				ST_CL_SETUP: state_next = ST_CL_CONF;
				ST_CL_CONF:  state_next = ST_POLL_RD;
				ST_POLL_CMD: state_next = ST_POLL_RD;
				ST_CF_STCMD: state_next = ST_CF_STRD;
				ST_CF_CMD:   state_next = ST_CF_DATA;
				ST_CF_DATA: begin
					mode_next  = ctrl_reg[fls_pkg::CTRL_CFG_LSB +: 2];
					state_next = ST_POLL_CMD;
				end
				ST_XSR_CMD:  state_next = ST_XSR_RD;
				ST_POLL_RD:  state_next = ST_CHECK;
				ST_CF_STRD:  state_next = ST_CF_CHK;
				ST_XSR_RD: begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end
				default: begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
				end
			endcase
		end
		if (is_read_st && cnt_reg == RD_SMP) begin
			if (state_reg == ST_XSR_RD)
				xsr_next = dq_s2_reg & fls_pkg::XSR_MASK;
			else
				sr_next = dq_s2_reg & fls_pkg::SR_MASK;
		end
		if (state_reg == ST_CHECK) begin
			cnt_next = 8'h00;
			if (!sr_reg[fls_pkg::SR_READY]) begin
				state_next = ST_POLL_RD;
			end else if (sr_reg[fls_pkg::SR_ERS_ERR] || sr_reg[fls_pkg::SR_PRG_ERR]) begin
				// Failure code stays in the captured copy; the device copy is wiped
				state_next = ST_CLR_SR;
			end else begin
				state_next = ST_IDLE;
				done_next  = 1'b1;
				if (is_clear_reg)
					undef_next = 1'b0;
			end
		end
		if (state_reg == ST_CF_CHK) begin
			cnt_next = 8'h00;
			if (sr_reg[fls_pkg::SR_READY] && !sr_reg[fls_pkg::SR_ERS_SUSP] && !sr_reg[fls_pkg::SR_PRG_SUSP]) begin
				state_next = ST_CF_CMD;
			end else begin
				state_next   = ST_IDLE;
				refused_next = 1'b1;
			end
		end
		// Software pulling protect low or powering down mid-clear scrambles the lock-bits
		if (state_reg != ST_IDLE && (!ctrl_next[fls_pkg::CTRL_WP_BIT] || ctrl_next[fls_pkg::CTRL_PD_BIT])) begin
			if (is_clear_reg && state_reg != ST_CL_SETUP)
				undef_next = 1'b1;
			if (is_clear_reg || ctrl_next[fls_pkg::CTRL_PD_BIT]) begin
				state_next   = ST_IDLE;
				refused_next = 1'b1;
			end
		end
		if (ctrl_next[fls_pkg::CTRL_PD_BIT])
			mode_next = fls_pkg::CFG_RESET;
	end

	always_comb begin
		pins_next.reset_powerdown_n = !ctrl_next[fls_pkg::CTRL_PD_BIT];
		pins_next.write_protect_n   = ctrl_next[fls_pkg::CTRL_WP_BIT];
		pins_next.ce_n    = 1'b1;
		pins_next.oe_n    = 1'b1;
		pins_next.we_n    = 1'b1;
		pins_next.dq_oe_n = 1'b1;
		pins_next.dq_out  = cmd_byte(state_next, ctrl_reg[fls_pkg::CTRL_CFG_LSB +: 2]);
		if (state_next inside {ST_CL_SETUP, ST_CL_CONF, ST_POLL_CMD, ST_CLR_SR, ST_CF_STCMD,
			ST_CF_CMD, ST_CF_DATA, ST_XSR_CMD}) begin
			// Data held one cycle past the strobe for hold time
			pins_next.dq_oe_n = cnt_next > 8'(fls_pkg::WE_CYC);
			pins_next.ce_n    = cnt_next >= 8'(fls_pkg::WE_CYC);
			pins_next.we_n    = cnt_next >= 8'(fls_pkg::WE_CYC);
		end else if (state_next inside {ST_POLL_RD, ST_CF_STRD, ST_XSR_RD}) begin
			pins_next.ce_n = cnt_next >= 8'(fls_pkg::RD_CYC);
			pins_next.oe_n = cnt_next >= 8'(fls_pkg::RD_CYC);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 8'h00;
			ctrl_reg     <= 10'h000;
			sr_reg       <= 8'h00;
			xsr_reg      <= 8'h00;
			mode_reg     <= fls_pkg::CFG_RESET;
			is_clear_reg <= 1'b0;
			done_reg     <= 1'b0;
			refused_reg  <= 1'b0;
			undef_reg    <= 1'b0;
			pulse_reg    <= 1'b0;
			prdata_reg   <= 32'h0000_0000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			pins_reg     <= {1'b1, 1'b0, 4'hf, 8'h00};
			dq_s1_reg    <= 8'h00;
			dq_s2_reg    <= 8'h00;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			ctrl_reg     <= ctrl_next;
			sr_reg       <= sr_next;
			xsr_reg      <= xsr_next;
			mode_reg     <= mode_next;
			is_clear_reg <= is_clear_next;
			done_reg     <= done_next;
			refused_reg  <= refused_next;
			undef_reg    <= undef_next;
			pulse_reg    <= pulse_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			pins_reg     <= pins_next;
			dq_s1_reg    <= flash_dq_in;
			dq_s2_reg    <= dq_s1_reg;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign flash   = pins_reg;

	sequence s_setup_done;
		state_reg == ST_CL_SETUP && bus_done;
	endsequence
	sequence s_confirm_start;
		state_reg == ST_CL_CONF && !pins_reg.we_n;
	endsequence

	property p_setup_confirm;
		@(posedge pclk) disable iff (!presetn)
		s_setup_done |=> s_confirm_start;
	endproperty
	a_setup_confirm: assert property (p_setup_confirm) else $error("confirm did not follow setup");

	property p_clear_needs_wp;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CL_SETUP && !pins_reg.we_n) |-> pins_reg.write_protect_n;
	endproperty
	a_clear_needs_wp: assert property (p_clear_needs_wp) else $error("lock clear issued with protect low");

	property p_cfg_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CF_DATA && !pins_reg.dq_oe_n) |-> pins_reg.dq_out[7:2] == 6'h00;
	endproperty
	a_cfg_upper_zero: assert property (p_cfg_upper_zero) else $error("config code upper bits not zero");

	property p_cfg_when_ready;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CF_CMD && cnt_reg == 8'h00) |->
			sr_reg[fls_pkg::SR_READY] && !sr_reg[fls_pkg::SR_ERS_SUSP] && !sr_reg[fls_pkg::SR_PRG_SUSP];
	endproperty
	a_cfg_when_ready: assert property (p_cfg_when_ready) else $error("config issued while busy or suspended");

	property p_error_clears;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CHECK && sr_reg[fls_pkg::SR_READY] && sr_reg[fls_pkg::SR_ERS_ERR]
			&& !ctrl_next[fls_pkg::CTRL_PD_BIT] && (ctrl_next[fls_pkg::CTRL_WP_BIT] || !is_clear_reg))
			|=> state_reg == ST_CLR_SR ##1 pins_reg.dq_out == OPC_CLEAR_SR;
	endproperty
	a_error_clears: assert property (p_error_clears) else $error("error not followed by status clear");

	property p_busy_repoll;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_CHECK && !sr_reg[fls_pkg::SR_READY] && !ctrl_next[fls_pkg::CTRL_PD_BIT]
			&& (ctrl_next[fls_pkg::CTRL_WP_BIT] || !is_clear_reg)) |=> state_reg == ST_POLL_RD && !done_reg;
	endproperty
	a_busy_repoll: assert property (p_busy_repoll) else $error("busy status not polled again");

	property p_pd_mode;
		@(posedge pclk) disable iff (!presetn)
		!pins_reg.reset_powerdown_n |-> mode_reg == fls_pkg::CFG_RESET;
	endproperty
	a_pd_mode: assert property (p_pd_mode) else $error("pin mode kept through power-down");

	property p_sr0_masked;
		@(posedge pclk) disable iff (!presetn)
		$changed(sr_reg) |-> !sr_reg[0] && $past(is_read_st);
	endproperty
	a_sr0_masked: assert property (p_sr0_masked) else $error("reserved status bit not masked");

	property p_abort_undef;
		@(posedge pclk) disable iff (!presetn)
		(is_clear_reg && state_reg inside {ST_CL_CONF, ST_POLL_RD, ST_CHECK}
			&& !ctrl_next[fls_pkg::CTRL_WP_BIT]) |=> undef_reg && state_reg == ST_IDLE;
	endproperty
	a_abort_undef: assert property (p_abort_undef) else $error("aborted clear not flagged");
endmodule

// ==== core/fls_pkg.sv ====
// Shared constants, types and register map for the flash lock/status host controller
package fls_pkg;
	localparam int CLK_MHZ = 100;

	// Our own APB register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;

	// Control register fields
	localparam int CTRL_CFG_LSB = 0;
	localparam int CTRL_WP_BIT  = 8;
	localparam int CTRL_PD_BIT  = 9;
	localparam logic [1:0] CFG_RESET = 2'h0;

	// Command register codes
	localparam logic [2:0] OP_CLEAR_LOCKS = 3'h1;
	localparam logic [2:0] OP_CONFIG_PIN  = 3'h2;
	localparam logic [2:0] OP_CLEAR_SR    = 3'h3;
	localparam logic [2:0] OP_READ_SR     = 3'h4;
	localparam logic [2:0] OP_READ_XSR    = 3'h5;

	// Status register fields
	localparam int STAT_XSR_LSB  = 8;
	localparam int STAT_BUSY     = 16;
	localparam int STAT_DONE     = 17;
	localparam int STAT_REFUSED  = 18;
	localparam int STAT_LOCK_UND = 19;
	localparam int STAT_PIN_LVL  = 20;
	localparam int STAT_PULSE    = 21;
	localparam int STAT_MODE_LSB = 22;

	// Device status bit positions
	localparam int SR_READY    = 7;
	localparam int SR_ERS_SUSP = 6;
	localparam int SR_ERS_ERR  = 5;
	localparam int SR_PRG_ERR  = 4;
	localparam int SR_PRG_SUSP = 2;
	localparam logic [7:0] SR_MASK  = 8'hfe;
	localparam logic [7:0] XSR_MASK = 8'h80;

	// Device opcode and config code layout
	localparam logic [7:0] OPC_PIN_CONFIG = 8'hb8;
	localparam logic [7:0] CFG_CODE_MASK  = 8'h03;

	// Pin timing
	localparam int WE_NS        = 60;
	localparam int WR_GAP_NS    = 30;
	localparam int RD_NS        = 150;
	localparam int STS_PULSE_NS = 250;
	localparam int WE_CYC       = (WE_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC      = (WR_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_CYC       = (RD_NS * CLK_MHZ + 999) / 1000;
	localparam int STS_MIN_CYC  = (STS_PULSE_NS * CLK_MHZ) / 2000;

	typedef struct packed {
		logic       reset_powerdown_n;
		logic       write_protect_n;
		logic       ce_n;
		logic       oe_n;
		logic       we_n;
		logic       dq_oe_n;
		logic [7:0] dq_out;
	} fls_pins_t;
endpackage

// ==== core/fls_sts_mon.sv ====
// Synchroniser and pulse detector for the device's completion output pin
`timescale 1ns/100ps
module fls_sts_mon #(
	parameter int MIN_CYC = fls_pkg::STS_MIN_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_in,
	output logic      level,
	output logic      done_pulse
);
	logic       s1_reg, s2_reg, s3_reg;
	logic [7:0] low_reg, low_next;
	logic       done_reg, done_next;

	always_comb begin
		low_next  = low_reg;
		done_next = 1'b0;
		if (!s2_reg) begin
			if (low_reg != 8'hff)
				low_next = low_reg + 8'h01;
		end else begin
			low_next = 8'h00;
		end
		// Glitches shorter than half the typical width are not counted
		if (s2_reg && !s3_reg && low_reg >= 8'(MIN_CYC))
			done_next = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg   <= 1'b1;
			s2_reg   <= 1'b1;
			s3_reg   <= 1'b1;
			low_reg  <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			s1_reg   <= pin_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			low_reg  <= low_next;
			done_reg <= done_next;
		end
	end

	assign level      = s3_reg;
	assign done_pulse = done_reg;

	property p_pulse_width;
		@(posedge pclk) disable iff (!presetn)
		done_reg |-> s3_reg && !$past(s3_reg) && $past(low_reg, 2) >= 8'(MIN_CYC - 1);
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("completion pulse accepted too short");
endmodule

// ==== verif/fls_dev_model.sv ====
// Behavioural flash device seen from its command and status pins
`timescale 1ns/100ps
module fls_dev_model #(
	parameter int BUSY_NS = 400
) (
	input  wire fls_pkg::fls_pins_t flash,
	input  wire logic               vpp_low,
	input  wire logic               ers_susp,
	output logic [7:0]              dq_in,
	output logic                    sts_pin
);
	logic [7:0] status;
	logic [7:0] locks;
	logic [7:0] cmd_log[$];
	logic [7:0] c;
	logic [7:0] rd_val;
	logic [1:0] pin_cfg;
	logic       busy;
	logic       xsr_mode;
	logic       setup_pend;
	logic       cfg_pend;
	logic       armed;
	logic       pulse_low;
	int         i;

	// Bit 0 is driven high on purpose so that the host must mask it
	initial begin
		status = 8'h81;
		locks = 8'hff;
		pin_cfg = 2'h0;
		{busy, xsr_mode, setup_pend, cfg_pend, armed, pulse_low} = 6'h0;
	end

	always @(negedge flash.reset_powerdown_n) begin
		pin_cfg = 2'h0;
		status = 8'h81;
		{xsr_mode, setup_pend, cfg_pend} = 3'h0;
	end

	// Strobes rise together, so the select is qualified at the falling edge
	always @(negedge flash.we_n) armed = !flash.ce_n;

	always @(posedge flash.we_n) begin
		if (armed && flash.reset_powerdown_n) begin
			c = flash.dq_out;
			cmd_log.push_back(c);
			xsr_mode = 1'b0;
			if (setup_pend) begin
				setup_pend = 1'b0;
				if (c != 8'hd0) status = status | 8'h30;
				else if (!flash.write_protect_n) status = status | 8'h22;
				else if (vpp_low) status = status | 8'h28;
				else begin
					busy = 1'b1;
					status[7] = 1'b0;
					for (i = 0; i < BUSY_NS / 10 && flash.write_protect_n && flash.reset_powerdown_n; i++) #10;
					if (i == BUSY_NS / 10) begin
						locks = 8'h00;
						status = 8'h81;
					end else begin
						locks = 8'ha5;
						status = 8'ha1;
					end
					busy = 1'b0;
				end
			end else if (cfg_pend) begin
				cfg_pend = 1'b0;
				if (c[7:2] != 6'h0) status = status | 8'h30;
				else pin_cfg = c[1:0];
			end else begin
				case (c)
					8'h60: setup_pend = 1'b1;
					8'hb8: cfg_pend = 1'b1;
					8'h71: xsr_mode = 1'b1;
					8'h50: status = 8'h81;
					default: ;
				endcase
			end
		end
	end

	// Stands in for an erase or program finishing, which the host never starts itself
	task automatic finish_op(input logic erase, input logic lock_bit);
		if (lock_bit && !flash.write_protect_n) begin
			status = status | (erase ? 8'h22 : 8'h12);
		end else if (pin_cfg[erase ? 0 : 1]) begin
			pulse_low = 1'b1;
			#250;
			pulse_low = 1'b0;
		end
	endtask

	// Reserved extended bits read high so the host must mask them
	assign rd_val = xsr_mode ? 8'hff : (status | {1'b0, ers_susp, 6'h0});
	assign dq_in = (!flash.ce_n && !flash.oe_n) ? rd_val : ~rd_val;
	assign sts_pin = !(busy && pin_cfg == 2'h0) && !pulse_low;
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the flash lock/status host controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        vpp_low;
	logic        ers_susp;
	logic        sts_pin;
	logic [7:0]  paddr;
	logic [7:0]  dq_in;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	int          bad_count;
	int          check_count;
	int          n0;
	fls_pkg::fls_pins_t flash;

	fls_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash(flash), .flash_dq_in(dq_in), .completion_output_pin(sts_pin));
	fls_dev_model dev_u (.flash(flash), .vpp_low(vpp_low), .ers_susp(ers_susp), .dq_in(dq_in),
		.sts_pin(sts_pin));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Read data and error are taken at the edge that samples pready high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cmd(input logic [2:0] op);
		n0 = dev_u.cmd_log.size();
		xfer(1'b1, fls_pkg::REG_CMD, {29'h0, op});
	endtask

	task wait_idle;
		do xfer(1'b0, fls_pkg::REG_STAT, 32'h0);
		while (rd[fls_pkg::STAT_BUSY] !== 1'b0);
	endtask

	task wait_dev_busy;
		int n;
		n = 0;
		while (dev_u.busy !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask

	initial begin
		#500000;
		bad_count++;
		end_of_test;
	end

	initial begin
		{psel, penable, pwrite, vpp_low, ers_susp, presetn} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, fls_pkg::REG_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		`CHK("protect reset", 1'b0, flash.write_protect_n)
		xfer(1'b0, 8'h0c, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		cmd(fls_pkg::OP_CLEAR_LOCKS);
		xfer(1'b0, fls_pkg::REG_STAT, 32'h0);
		`CHK("refused clear", 1'b1, rd[fls_pkg::STAT_REFUSED])
		`CHK("locks kept", 8'hff, dev_u.locks)
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h100);
		cmd(fls_pkg::OP_CLEAR_LOCKS);
		wait_dev_busy;
		`CHK("pin while busy", 1'b0, sts_pin)
		wait_idle;
		`CHK("locks cleared", 8'h00, dev_u.locks)
		`CHK("setup byte", 8'h60, dev_u.cmd_log[n0])
		`CHK("confirm byte", 8'hd0, dev_u.cmd_log[n0+1])
		`CHK("status ok", 8'h80, rd[7:0])
		`CHK("pin ready", 1'b1, sts_pin)
		dev_u.locks = 8'h5a;
		vpp_low <= 1'b1;
		cmd(fls_pkg::OP_CLEAR_LOCKS);
		wait_idle;
		`CHK("supply status", 8'ha8, rd[7:0])
		`CHK("locks on low supply", 8'h5a, dev_u.locks)
		`CHK("error cleared", 8'h50, dev_u.cmd_log[$])
		vpp_low <= 1'b0;
		cmd(fls_pkg::OP_CLEAR_LOCKS);
		wait_dev_busy;
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h0);
		wait_idle;
		`CHK("locks unknown", 1'b1, rd[fls_pkg::STAT_LOCK_UND])
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h100);
		cmd(fls_pkg::OP_CLEAR_LOCKS);
		wait_idle;
		`CHK("locks known", 1'b0, rd[fls_pkg::STAT_LOCK_UND])
		`CHK("locks repeat", 8'h00, dev_u.locks)
		for (int i = 1; i <= 4; i++) begin
			xfer(1'b1, fls_pkg::REG_CTRL, 32'h100 | (i % 4));
			cmd(fls_pkg::OP_CONFIG_PIN);
			wait_idle;
			`CHK("mode mirror", 2'(i % 4), rd[23:22])
			`CHK("config opcode", 8'hb8, dev_u.cmd_log[n0+1])
			`CHK("config code", 8'(i % 4), dev_u.cmd_log[n0+2])
			`CHK("device mode", 2'(i % 4), dev_u.pin_cfg)
		end
		ers_susp <= 1'b1;
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h102);
		cmd(fls_pkg::OP_CONFIG_PIN);
		wait_idle;
		`CHK("config refused", 1'b1, rd[fls_pkg::STAT_REFUSED])
		`CHK("suspend seen", 1'b1, rd[fls_pkg::SR_ERS_SUSP])
		`CHK("mode kept", 2'h0, dev_u.pin_cfg)
		ers_susp <= 1'b0;
		cmd(fls_pkg::OP_READ_XSR);
		wait_idle;
		`CHK("ext status", 8'h80, rd[15:8])
		cmd(fls_pkg::OP_CLEAR_SR);
		wait_idle;
		`CHK("clear status byte", 8'h50, dev_u.cmd_log[n0])
		cmd(fls_pkg::OP_READ_SR);
		wait_idle;
		`CHK("read status byte", 8'h70, dev_u.cmd_log[n0])
		`CHK("status read", 8'h80, rd[7:0])
		`CHK("done flag", 1'b1, rd[fls_pkg::STAT_DONE])
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h101);
		cmd(fls_pkg::OP_CONFIG_PIN);
		wait_idle;
		`CHK("pulse mode set", 2'h1, dev_u.pin_cfg)
		dev_u.finish_op(1'b0, 1'b0);
		repeat (5) @(posedge pclk);
		xfer(1'b0, fls_pkg::REG_STAT, 32'h0);
		`CHK("no program pulse", 1'b0, rd[fls_pkg::STAT_PULSE])
		dev_u.finish_op(1'b1, 1'b1);
		repeat (5) @(posedge pclk);
		xfer(1'b0, fls_pkg::REG_STAT, 32'h0);
		`CHK("erase pulse seen", 1'b1, rd[fls_pkg::STAT_PULSE])
		`CHK("pin level high", 1'b1, rd[fls_pkg::STAT_PIN_LVL])
		`CHK("lock override", 8'h80, dev_u.status & 8'hfe)
		xfer(1'b1, fls_pkg::REG_CTRL, 32'h200);
		repeat (3) @(posedge pclk);
		`CHK("power down pin", 1'b0, flash.reset_powerdown_n)
		`CHK("mode after power down", 2'h0, dev_u.pin_cfg)
		`CHK("pin in power down", 1'b1, sts_pin)
		end_of_test;
	end
endmodule
